// file: shared/pmic_cfg_pkg.sv
// Package for the write-only two-wire configuration slave.
// Assumes nothing beyond a SystemVerilog compiler; no file imports it.
package pmic_cfg_pkg;

	// Full first byte, direction bit included, that the slave answers to.
	localparam logic [7:0] SLAVE_ADDR_BYTE = 8'h98;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
	localparam logic [3:0] ACK_SLOT        = 4'h8;

	// Register-select values.
	localparam logic [7:0] CHARGER_CONFIG_SEL = 8'h00;
	localparam logic [7:0] SYSTEM_LDO1_SEL    = 8'h01;
	localparam logic [7:0] LDO2_TO_LDO5_SEL   = 8'h02;

	// Field positions of charger_config.
	localparam int WATCHDOG_BIT  = 7;
	localparam int RECHARGE_LSB  = 5;
	localparam int CHARGE_LSB    = 2;
	localparam int TERM_LSB      = 0;
	// Field positions of system_and_ldo1_voltage.
	localparam int SYSTEM_BIT    = 2;
	localparam int LDO1_LSB      = 0;
	// Field positions of ldo2_to_ldo5_voltage, two bits each from bit 0 upward.
	localparam int LDO2_LSB      = 0;

	// Reset values and masks.
	localparam logic [7:0] CHARGER_CONFIG_RESET = 8'h00;
	localparam logic [7:0] SYSTEM_LDO1_RESET    = 8'h00;
	localparam logic [7:0] LDO2_TO_LDO5_RESET   = 8'h00;
	localparam logic [7:0] SYSTEM_LDO1_MASK     = 8'h07;
	localparam logic [2:0] CHARGE_CODE_FIXED    = 3'h0;

	// What a received byte is, as seen by the link logic.
	typedef enum logic [1:0] {
		KIND_ADDRESS = 2'h0,
		KIND_SELECT  = 2'h1,
		KIND_DATA    = 2'h3
	} byte_kind_t;

	typedef struct packed {
		byte_kind_t kind;
		logic [7:0] data;
	} link_byte_t;

	// How the device came to be powered.
	typedef enum logic [1:0] {
		POWER_OFF     = 2'h0,
		POWER_CHARGER = 2'h1,
		POWER_KEY     = 2'h3
	} power_state_t;

	typedef struct packed {
		logic             watchdog_disable;
		logic [1:0]       recharge_threshold_sel;
		logic [2:0]       charge_current_sel;
		logic [1:0]       termination_sel;
		logic             system_control_bit;
		logic [4:0][1:0]  ldo_voltage_sel;
	} config_t;

endpackage

// file: hdl/sync2.sv
// Two-flip-flop synchroniser for levels entering the system clock domain.
// Assumes each bit changes slowly compared with the clock; no bus coherence.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] first_reg;
	logic [WIDTH-1:0] second_reg;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			first_reg  <= '0;
			second_reg <= '0;
		end else begin
			first_reg  <= async_in;
			second_reg <= first_reg;
		end
	end

	assign sync_out = second_reg;
endmodule
`default_nettype wire

// file: hdl/link_receiver.sv
// Serial-clock side of the slave: shifts bits, drives the acknowledge, hands bytes over.
// Assumes link_rstn is held low outside a frame and released only while the clock is low.
`timescale 1ns/1ps
`default_nettype none
module link_receiver (
	input  wire logic                     scl_clock,
	input  wire logic                     rstn,
	input  wire logic                     link_rstn,
	input  wire logic                     sda_in,
	output logic                          sda_drive_n,
	output logic                          byte_toggle,
	output pmic_cfg_pkg::link_byte_t      byte_out
);
	logic [3:0]                  bit_cnt_reg,   bit_cnt_next;
	logic [7:0]                  shift_reg,     shift_next;
	pmic_cfg_pkg::byte_kind_t    kind_reg,      kind_next;
	logic                        addr_ok_reg,   addr_ok_next;
	logic                        ack_due_reg,   ack_due_next;
	logic                        toggle_reg,    toggle_next;
	pmic_cfg_pkg::link_byte_t    byte_reg,      byte_next;
	logic                        drive_reg,     drive_next;
	logic [7:0]                  full_byte;

	always_comb begin
		full_byte    = {shift_reg[6:0], sda_in};
		bit_cnt_next = bit_cnt_reg;
		shift_next   = shift_reg;
		kind_next    = kind_reg;
		addr_ok_next = addr_ok_reg;
		ack_due_next = ack_due_reg;
		toggle_next  = toggle_reg;
		byte_next    = byte_reg;
		if (bit_cnt_reg == pmic_cfg_pkg::ACK_SLOT) begin
			bit_cnt_next = 4'h0;
			ack_due_next = 1'b0;
		end else begin
			shift_next   = full_byte;
			bit_cnt_next = bit_cnt_reg + 4'h1;
			if (bit_cnt_reg == pmic_cfg_pkg::BITS_PER_BYTE - 4'h1) begin
				if (kind_reg == pmic_cfg_pkg::KIND_ADDRESS) begin
					addr_ok_next = (full_byte == pmic_cfg_pkg::SLAVE_ADDR_BYTE);
					ack_due_next = addr_ok_next;
					kind_next    = pmic_cfg_pkg::KIND_SELECT;
				end else begin
					ack_due_next = addr_ok_reg;
					if (addr_ok_reg) begin
						byte_next   = '{kind: kind_reg, data: full_byte};
						toggle_next = ~toggle_reg;
					end
					kind_next = pmic_cfg_pkg::KIND_DATA;
				end
			end
		end
	end

	// Bit state restarts with every frame; the handover pair only with the device reset,
	// since clearing the toggle would look like a fresh byte on the other side.
	always_ff @(posedge scl_clock or negedge link_rstn) begin
		if (!link_rstn) begin
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			kind_reg    <= pmic_cfg_pkg::KIND_ADDRESS;
			addr_ok_reg <= 1'b0;
			ack_due_reg <= 1'b0;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			shift_reg   <= shift_next;
			kind_reg    <= kind_next;
			addr_ok_reg <= addr_ok_next;
			ack_due_reg <= ack_due_next;
		end
	end

	always_ff @(posedge scl_clock or negedge rstn) begin
		if (!rstn) begin
			toggle_reg <= 1'b0;
			byte_reg   <= '0;
		end else begin
			toggle_reg <= toggle_next;
			byte_reg   <= byte_next;
		end
	end

	// The data line changes only while the clock is low, so the acknowledge moves on falling edges.
	always_comb begin
		drive_next = (bit_cnt_reg == pmic_cfg_pkg::ACK_SLOT) && ack_due_reg;
	end

	always_ff @(negedge scl_clock or negedge link_rstn) begin
		if (!link_rstn) begin
			drive_reg <= 1'b0;
		end else begin
			drive_reg <= drive_next;
		end
	end

	assign sda_drive_n = ~drive_reg;
	assign byte_toggle = toggle_reg;
	assign byte_out    = byte_reg;
endmodule
`default_nettype wire

// file: hdl/pmic_config_slave.sv
// Write-only two-wire configuration slave with power-source dependent register retention.
// Assumes the serial clock pin drives scl_clock directly and that supply and enable pins
// are clean digital levels; all of them are resynchronised here.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Data falling while clock is high marks a START; the device detects it.
// - Data rising while clock is high marks a STOP; the transfer ends.
// - Bytes are eight bits, most significant bit first.
// - Only the full first byte 0x98 is answered.
// - Ninth bit is acknowledge; device pulls data low for accepted bytes.
// - Register-select byte follows address, then data written to that register.
// - Charge-current field is bits 4:2 of register 0; code 000 is fixed.
// - Nonzero charge-current codes pick fractions of the resistor-set current.
// - Two-bit termination field picks end-of-charge current, default 00.
// - Two-bit recharge field picks recharge threshold, default 00.
// - Watchdog bit 0 keeps watchdog running; 1 stops and clears it.
// - Five regulators each have a two-bit voltage field, default 00.
// - After key power-on, registers hold until hold enable falls or supplies vanish.
// - Charger-only power-on: losing the charger shuts down and clears registers.
// - Key power-on with charger removed then restored forces charge code 000.
// - Next write to any register restores the programmed charge code.
// - Only writes are supported; registers cannot be read back.
module pmic_config_slave (
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire logic                  scl_clock,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_drive_n,
	input  wire logic                  key_press_n,
	input  wire logic                  hold_enable,
	input  wire logic                  charger_supply_input,
	input  wire logic                  battery_supply,
	output logic                       device_on,
	output logic [2:0]                 charge_current_code,
	output pmic_cfg_pkg::config_t      config_out
);
	// Link pins and power pins, resynchronised.
	logic [1:0]                  bus_sync;
	logic [3:0]                  power_sync;
	logic                        scl_s;
	logic                        sda_s;
	logic                        key_s;
	logic                        hold_s;
	logic                        charger_s;
	logic                        battery_s;
	logic                        toggle_s;
	logic                        link_toggle;
	pmic_cfg_pkg::link_byte_t    link_byte;

	sync2 #(
		.WIDTH(2)
	) bus_sync_inst (
		.clock    (clock),
		.rstn     (rstn),
		.async_in ({scl_in, sda_in}),
		.sync_out (bus_sync)
	);

	sync2 #(
		.WIDTH(4)
	) power_sync_inst (
		.clock    (clock),
		.rstn     (rstn),
		.async_in ({~key_press_n, hold_enable, charger_supply_input, battery_supply}),
		.sync_out (power_sync)
	);

	sync2 #(
		.WIDTH(1)
	) toggle_sync_inst (
		.clock    (clock),
		.rstn     (rstn),
		.async_in (link_toggle),
		.sync_out (toggle_s)
	);

	assign scl_s     = bus_sync[1];
	assign sda_s     = bus_sync[0];
	assign key_s     = power_sync[3];
	assign hold_s    = power_sync[2];
	assign charger_s = power_sync[1];
	assign battery_s = power_sync[0];

	// Bus condition detection on the resynchronised lines.
	logic scl_prev_reg,  scl_prev_next;
	logic sda_prev_reg,  sda_prev_next;
	logic in_frame_reg,  in_frame_next;
	logic link_run_reg,  link_run_next;
	logic start_seen;
	logic stop_seen;

	always_comb begin
		scl_prev_next = scl_s;
		sda_prev_next = sda_s;
		start_seen    = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
		stop_seen     = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
		in_frame_next = in_frame_reg;
		link_run_next = link_run_reg;
		if (start_seen) begin
			in_frame_next = 1'b1;
			link_run_next = 1'b0;
		end else if (stop_seen) begin
			in_frame_next = 1'b0;
			link_run_next = 1'b0;
		end else if (in_frame_reg && !scl_s) begin
			// Released only while the clock is low, so no link edge can race the release.
			link_run_next = 1'b1;
		end
		if (!device_on) begin
			link_run_next = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			in_frame_reg <= 1'b0;
			link_run_reg <= 1'b0;
		end else begin
			scl_prev_reg <= scl_prev_next;
			sda_prev_reg <= sda_prev_next;
			in_frame_reg <= in_frame_next;
			link_run_reg <= link_run_next;
		end
	end

	link_receiver link_inst (
		.scl_clock   (scl_clock),
		.rstn        (rstn),
		.link_rstn   (link_run_reg),
		.sda_in      (sda_in),
		.sda_drive_n (sda_drive_n),
		.byte_toggle (link_toggle),
		.byte_out    (link_byte)
	);

	// The slave only ever pulls the data line low.
	assign sda_out = 1'b0;

	// Byte handover: the link byte stays put for a whole byte time after its toggle moves.
	logic toggle_prev_reg, toggle_prev_next;
	logic byte_event;

	always_comb begin
		toggle_prev_next = toggle_s;
		byte_event       = toggle_s ^ toggle_prev_reg;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			toggle_prev_reg <= 1'b0;
		end else begin
			toggle_prev_reg <= toggle_prev_next;
		end
	end

	// Power source tracking.
	pmic_cfg_pkg::power_state_t power_reg, power_next;
	logic hold_prev_reg,      hold_prev_next;
	logic charger_prev_reg,   charger_prev_next;
	logic charger_lost_reg,   charger_lost_next;
	logic force_fixed_reg,    force_fixed_next;
	logic clear_regs;
	logic write_event;

	always_comb begin
		power_next        = power_reg;
		hold_prev_next    = hold_s;
		charger_prev_next = charger_s;
		charger_lost_next = charger_lost_reg;
		force_fixed_next  = force_fixed_reg;
		clear_regs        = 1'b0;
		unique case (power_reg)
			pmic_cfg_pkg::POWER_OFF: begin
				clear_regs = 1'b1;
				if (key_s) begin
					power_next = pmic_cfg_pkg::POWER_KEY;
				end else if (charger_s) begin
					power_next = pmic_cfg_pkg::POWER_CHARGER;
				end
			end
			pmic_cfg_pkg::POWER_CHARGER: begin
				if (key_s) begin
					power_next = pmic_cfg_pkg::POWER_KEY;
				end else if (!charger_s) begin
					power_next = pmic_cfg_pkg::POWER_OFF;
				end
			end
			pmic_cfg_pkg::POWER_KEY: begin
				if ((hold_prev_reg && !hold_s) || (!battery_s && !charger_s)) begin
					power_next = pmic_cfg_pkg::POWER_OFF;
				end else begin
					if (charger_prev_reg && !charger_s) begin
						charger_lost_next = 1'b1;
					end
					// A write in the same cycle as a reconnect loses to the reconnect.
					if (write_event) begin
						force_fixed_next = 1'b0;
					end
					if (charger_lost_reg && !charger_prev_reg && charger_s) begin
						force_fixed_next  = 1'b1;
						charger_lost_next = 1'b0;
					end
				end
			end
			default: begin
				power_next = pmic_cfg_pkg::POWER_OFF;
			end
		endcase
		if (power_next == pmic_cfg_pkg::POWER_OFF) begin
			charger_lost_next = 1'b0;
			force_fixed_next  = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			power_reg        <= pmic_cfg_pkg::POWER_OFF;
			hold_prev_reg    <= 1'b0;
			charger_prev_reg <= 1'b0;
			charger_lost_reg <= 1'b0;
			force_fixed_reg  <= 1'b0;
		end else begin
			power_reg        <= power_next;
			hold_prev_reg    <= hold_prev_next;
			charger_prev_reg <= charger_prev_next;
			charger_lost_reg <= charger_lost_next;
			force_fixed_reg  <= force_fixed_next;
		end
	end

	assign device_on = (power_reg != pmic_cfg_pkg::POWER_OFF);

	// Register file, written only; nothing in it is ever shifted back out.
	logic [7:0] select_reg,  select_next;
	logic [7:0] charger_reg, charger_next;
	logic [7:0] sysldo_reg,  sysldo_next;
	logic [7:0] ldo_reg,     ldo_next;

	always_comb begin
		select_next  = select_reg;
		charger_next = charger_reg;
		sysldo_next  = sysldo_reg;
		ldo_next     = ldo_reg;
		write_event  = 1'b0;
		if (clear_regs) begin
			select_next  = pmic_cfg_pkg::CHARGER_CONFIG_SEL;
			charger_next = pmic_cfg_pkg::CHARGER_CONFIG_RESET;
			sysldo_next  = pmic_cfg_pkg::SYSTEM_LDO1_RESET;
			ldo_next     = pmic_cfg_pkg::LDO2_TO_LDO5_RESET;
		end else if (byte_event) begin
			if (link_byte.kind == pmic_cfg_pkg::KIND_SELECT) begin
				select_next = link_byte.data;
			end else if (link_byte.kind == pmic_cfg_pkg::KIND_DATA) begin
				// Consecutive data bytes fill consecutive registers.
				select_next = select_reg + 8'h01;
				write_event = 1'b1;
				unique case (select_reg)
					pmic_cfg_pkg::CHARGER_CONFIG_SEL: charger_next = link_byte.data;
					pmic_cfg_pkg::SYSTEM_LDO1_SEL:
						sysldo_next = link_byte.data & pmic_cfg_pkg::SYSTEM_LDO1_MASK;
					pmic_cfg_pkg::LDO2_TO_LDO5_SEL:   ldo_next = link_byte.data;
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			select_reg  <= pmic_cfg_pkg::CHARGER_CONFIG_SEL;
			charger_reg <= pmic_cfg_pkg::CHARGER_CONFIG_RESET;
			sysldo_reg  <= pmic_cfg_pkg::SYSTEM_LDO1_RESET;
			ldo_reg     <= pmic_cfg_pkg::LDO2_TO_LDO5_RESET;
		end else begin
			select_reg  <= select_next;
			charger_reg <= charger_next;
			sysldo_reg  <= sysldo_next;
			ldo_reg     <= ldo_next;
		end
	end

	// Field outputs, registered so the analog side never sees decode glitches.
	pmic_cfg_pkg::config_t config_reg,      config_next;
	logic [2:0]            charge_code_reg, charge_code_next;

	always_comb begin
		config_next.watchdog_disable       = charger_reg[pmic_cfg_pkg::WATCHDOG_BIT];
		config_next.recharge_threshold_sel =
			charger_reg[pmic_cfg_pkg::RECHARGE_LSB +: 2];
		config_next.charge_current_sel     = charger_reg[pmic_cfg_pkg::CHARGE_LSB +: 3];
		config_next.termination_sel        = charger_reg[pmic_cfg_pkg::TERM_LSB +: 2];
		config_next.system_control_bit     = sysldo_reg[pmic_cfg_pkg::SYSTEM_BIT];
		config_next.ldo_voltage_sel[0]     = sysldo_reg[pmic_cfg_pkg::LDO1_LSB +: 2];
		for (int i = 0; i < 4; i++) begin
			config_next.ldo_voltage_sel[i+1] = ldo_reg[pmic_cfg_pkg::LDO2_LSB + 2*i +: 2];
		end
		// The stored code survives the override, which is why the next write can restore it.
		if (force_fixed_reg) begin
			charge_code_next = pmic_cfg_pkg::CHARGE_CODE_FIXED;
		end else begin
			charge_code_next = charger_reg[pmic_cfg_pkg::CHARGE_LSB +: 3];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			config_reg      <= '0;
			charge_code_reg <= pmic_cfg_pkg::CHARGE_CODE_FIXED;
		end else begin
			config_reg      <= config_next;
			charge_code_reg <= charge_code_next;
		end
	end

	assign config_out          = config_reg;
	assign charge_current_code = charge_code_reg;
endmodule
`default_nettype wire

// file: verif/pmic_config_slave_sva.sv
// Checker for the configuration slave, watching only the top module's ports.
// Assumes it is bound to pmic_config_slave and that rstn resets both domains.
`timescale 1ns/1ps
`default_nettype none
module pmic_config_slave_sva (
	input wire logic                  clock,
	input wire logic                  rstn,
	input wire logic                  scl_clock,
	input wire logic                  scl_in,
	input wire logic                  sda_in,
	input wire logic                  sda_out,
	input wire logic                  sda_drive_n,
	input wire logic                  key_press_n,
	input wire logic                  hold_enable,
	input wire logic                  charger_supply_input,
	input wire logic                  battery_supply,
	input wire logic                  device_on,
	input wire logic [2:0]            charge_current_code,
	input wire pmic_cfg_pkg::config_t config_out
);
	property p_sda_out_low;
		@(posedge clock) disable iff (!rstn) sda_out == 1'b0;
	endproperty
	a_sda_out_low: assert property (p_sda_out_low)
		else $error("data pin driven high");
	// One acknowledge slot, then eight data bits with the line left alone.
	property p_ack_spacing;
		@(negedge scl_clock) disable iff (!rstn) !sda_drive_n |=> sda_drive_n [*8];
	endproperty
	a_ack_spacing: assert property (p_ack_spacing)
		else $error("acknowledge not one slot per byte");
	property p_off_clear;
		@(posedge clock) disable iff (!rstn)
			!device_on [*4] |-> config_out == '0 && charge_current_code == 3'h0;
	endproperty
	a_off_clear: assert property (p_off_clear)
		else $error("fields kept while off");
	property p_off_no_ack;
		@(posedge clock) disable iff (!rstn) !device_on [*4] |-> sda_drive_n;
	endproperty
	a_off_no_ack: assert property (p_off_no_ack)
		else $error("acknowledge while off");
	property p_key_on;
		@(posedge clock) disable iff (!rstn)
			$fell(key_press_n) && !device_on |-> ##[2:5] device_on;
	endproperty
	a_key_on: assert property (p_key_on)
		else $error("key did not power on");
	property p_charger_on;
		@(posedge clock) disable iff (!rstn)
			$rose(charger_supply_input) && !device_on |-> ##[2:5] device_on;
	endproperty
	a_charger_on: assert property (p_charger_on)
		else $error("charger did not power on");
	property p_supplies_gone;
		@(posedge clock) disable iff (!rstn)
			(!charger_supply_input && !battery_supply && key_press_n) [*6] |-> !device_on;
	endproperty
	a_supplies_gone: assert property (p_supplies_gone)
		else $error("on without any supply");
	property p_code_or_fixed;
		@(posedge clock) disable iff (!rstn)
			charge_current_code == config_out.charge_current_sel
			|| charge_current_code == pmic_cfg_pkg::CHARGE_CODE_FIXED;
	endproperty
	a_code_or_fixed: assert property (p_code_or_fixed)
		else $error("effective charge code wrong");
endmodule
`default_nettype wire

// file: verif/i2c_master_model.sv
// Two-wire bus master model driving the clock and data lines open-drain.
// Assumes the bench resolves both lines with pull-ups; the clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	output logic      scl_pull,
	output logic      sda_pull,
	input  wire logic sda_line
);
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// The odd first delay keeps serial edges away from system clock edges.
	task automatic start_cond();
		sda_pull = 1'b0;
		#42 scl_pull = 1'b0;
		#40 sda_pull = 1'b1;
		#40 scl_pull = 1'b1;
		#40;
	endtask
	task automatic send_byte(input logic [7:0] value, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_pull = !value[i];
			#40 scl_pull = 1'b0;
			#80 scl_pull = 1'b1;
			#40;
		end
		sda_pull = 1'b0;
		#40 scl_pull = 1'b0;
		#40 ack = !sda_line;
		#40 scl_pull = 1'b1;
		#40;
	endtask
	task automatic stop_cond();
		sda_pull = 1'b1;
		#40 scl_pull = 1'b0;
		#40 sda_pull = 1'b0;
		#80;
	endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench: serial write frames from the master model plus supply sequencing.
// Assumes the checker is bound below and the serial clock runs only within frames.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                  clock = 1'b0;
	logic                  rstn = 1'b0;
	logic                  key_press_n = 1'b1;
	logic                  hold_enable = 1'b1;
	logic                  charger_supply_input = 1'b0;
	logic                  battery_supply = 1'b0;
	logic                  scl_pull;
	logic                  sda_pull;
	logic                  scl_line;
	logic                  sda_line;
	logic                  sda_out;
	logic                  sda_drive_n;
	logic                  device_on;
	logic [2:0]            charge_current_code;
	pmic_cfg_pkg::config_t config_out;
	pmic_cfg_pkg::config_t held;
	logic [7:0]            fb [5];
	logic [7:0]            bad [3] = '{8'h99, 8'h9a, 8'h18};
	logic [7:0]            d0;
	logic [7:0]            d1;
	logic [7:0]            d2;
	logic [2:0]            c;
	int                    failures = 0;
	int                    samples_checked = 0;
	always #2.5 clock = ~clock;
	assign scl_line = !scl_pull;
	assign sda_line = !(sda_pull || !sda_drive_n);
	pmic_config_slave dut_u (.clock(clock), .rstn(rstn), .scl_clock(scl_line),
		.scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
		.key_press_n(key_press_n), .hold_enable(hold_enable),
		.charger_supply_input(charger_supply_input), .battery_supply(battery_supply),
		.device_on(device_on), .charge_current_code(charge_current_code),
		.config_out(config_out));
	i2c_master_model master_u (.scl_pull(scl_pull), .sda_pull(sda_pull), .sda_line(sda_line));
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic power(input logic k, input logic h, input logic ch, input logic b);
		@(posedge clock);
		key_press_n <= k;
		hold_enable <= h;
		charger_supply_input <= ch;
		battery_supply <= b;
		repeat (24) @(posedge clock);
	endtask
	task automatic frame(input int n, input logic [4:0] exp_ack);
		logic ack;
		master_u.start_cond();
		for (int i = 0; i < n; i++) begin
			master_u.send_byte(fb[i], ack);
			check(32'(ack), 32'(exp_ack[i]), "acknowledge");
		end
		master_u.stop_cond();
		repeat (4) @(posedge clock);
	endtask
	task automatic fields();
		check(32'(config_out), 32'(held), "fields");
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#400_000;
		failures++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		results();
	end
	initial begin
		held = '0;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		fields();
		check(32'(sda_drive_n), 32'h1, "idle data line");
		fb = '{8'h98, 8'h00, 8'hff, 8'h00, 8'h00};
		frame(3, 5'h00);
		fields();
		$display("test reset_and_off done");
		power(1'b0, 1'b1, 1'b0, 1'b1);
		power(1'b1, 1'b1, 1'b0, 1'b1);
		check(32'(device_on), 32'h1, "key power");
		for (int k = 0; k < 8; k++) begin
			c = 3'(k);
			d0 = {c[0], c[1:0], c, c[1:0]};
			d1 = {5'h1f, c[2], c[1:0] ^ 2'h2};
			d2 = 8'he4 ^ {4{c[1:0]}};
			fb = '{8'h98, 8'h00, d0, d1, d2};
			frame(5, 5'h1f);
			held = pmic_cfg_pkg::config_t'({d0, d1[2], d2, d1[1:0]});
			fields();
			check(32'(charge_current_code), 32'(c), "charge code");
		end
		$display("test field_codes done");
		for (int a = 0; a < 3; a++) begin
			fb = '{bad[a], 8'h00, 8'h00, 8'h00, 8'h00};
			frame(3, 5'h00);
			fields();
		end
		fb = '{8'h98, 8'h02, 8'h4e, 8'h55, 8'h00};
		frame(4, 5'h0f);
		held.ldo_voltage_sel[4:1] = 8'h4e;
		fields();
		$display("test refused_and_unmapped done");
		power(1'b1, 1'b1, 1'b1, 1'b1);
		check(32'(charge_current_code), 32'h7, "no override yet");
		power(1'b1, 1'b1, 1'b0, 1'b1);
		power(1'b1, 1'b1, 1'b1, 1'b1);
		check(32'(charge_current_code), 32'h0, "forced code");
		fields();
		fb = '{8'h98, 8'h01, 8'h04, 8'h00, 8'h00};
		frame(3, 5'h07);
		held.system_control_bit = 1'b1;
		held.ldo_voltage_sel[0] = 2'h0;
		check(32'(charge_current_code), 32'h7, "restored code");
		fields();
		$display("test override done");
		power(1'b1, 1'b1, 1'b0, 1'b1);
		check(32'(device_on), 32'h1, "kept on battery");
		fields();
		power(1'b1, 1'b0, 1'b0, 1'b1);
		held = '0;
		check(32'(device_on), 32'h0, "hold released");
		fields();
		power(1'b1, 1'b1, 1'b1, 1'b1);
		check(32'(device_on), 32'h1, "charger power");
		fb = '{8'h98, 8'h00, 8'hff, 8'h00, 8'h00};
		frame(3, 5'h07);
		check(32'(charge_current_code), 32'h7, "charger write");
		power(1'b1, 1'b1, 1'b0, 1'b1);
		check(32'(device_on), 32'h0, "charger lost");
		power(1'b1, 1'b1, 1'b1, 1'b1);
		fields();
		$display("test power_sources done");
		power(1'b0, 1'b1, 1'b0, 1'b1);
		power(1'b1, 1'b1, 1'b0, 1'b0);
		check(32'(device_on), 32'h0, "supplies gone");
		$display("test supplies_gone done");
		results();
	end
endmodule
bind pmic_config_slave pmic_config_slave_sva chk_u (.clock(clock), .rstn(rstn),
	.scl_clock(scl_clock), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_drive_n(sda_drive_n), .key_press_n(key_press_n), .hold_enable(hold_enable),
	.charger_supply_input(charger_supply_input), .battery_supply(battery_supply),
	.device_on(device_on), .charge_current_code(charge_current_code),
	.config_out(config_out));
`default_nettype wire
